// File: hw/vdac_input_latch.sv
// Notes on behaviour
// - all data and control inputs are captured together on the falling clock edge.
// - the six upper pixel bits are decoded into 63 thermometer segment lines before the register.
// - the four lower pixel bits are registered undecoded alongside the segments, 67 stages in all.
// - pedestal force, tip force and polarity swap are active high.
// - with no control asserted the switches follow the latched pixel code only.
// - pedestal force sets every data segment and turns on the pedestal switch, ignoring the code.
// - tip force overrides code and pedestal force and turns on the tip switch.
// - polarity swap touches only the gray-scale path, never the pedestal or tip levels.
// - polarity swap high reverses the code-to-level mapping.
// - normally all ones gives the top level and all zeros the bottom; swap exchanges them.
`timescale 1ns/100ps
`default_nettype none
module vdac_input_latch
  import vdac_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic [PIX_W-1:0] i_pixel,
  input  wire logic             i_polarity_swap,
  input  wire logic             i_pedestal_force,
  input  wire logic             i_tip_force,
  output logic [SEG_N-1:0]      o_segment,
  output logic [LSB_W-1:0]      o_fine,
  output logic                  o_pedestal_switch,
  output logic                  o_tip_switch
);

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers (pins come from outside the clock domain)

  video_in_t in_meta_reg;
  video_in_t in_sync_reg;
  video_in_t in_now;

  assign in_now = '{polarity_swap:  i_polarity_swap,
                    pedestal_force: i_pedestal_force,
                    tip_force:      i_tip_force,
                    pixel:          i_pixel};

  always_ff @(negedge i_sys_clk) begin
    in_meta_reg <= in_now;
    in_sync_reg <= in_meta_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gray-scale path

  logic [PIX_W-1:0] gray_code;
  logic [SEG_N-1:0] seg_decoded;

  assign gray_code = in_sync_reg.polarity_swap ? ~in_sync_reg.pixel : in_sync_reg.pixel;

  vdac_therm_decoder u_decoder (
    .i_code    (gray_code[PIX_W-1:LSB_W]),
    .o_segment (seg_decoded)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // switch selection and 67-stage register bank

  switch_word_t word_reg;
  switch_word_t word_next;

  always_comb begin
    word_next.segment         = seg_decoded;
    word_next.fine            = gray_code[LSB_W-1:0];
    word_next.pedestal_switch = 1'b0;
    word_next.tip_switch      = 1'b0;
    if (in_sync_reg.tip_force) begin
      word_next.segment         = SEG_ALL_SET;
      word_next.fine            = LSB_ALL_SET;
      word_next.pedestal_switch = 1'b0;
      word_next.tip_switch      = 1'b1;
    end else if (in_sync_reg.pedestal_force) begin
      word_next.segment         = SEG_ALL_SET;
      word_next.fine            = LSB_ALL_SET;
      word_next.pedestal_switch = 1'b1;
      word_next.tip_switch      = 1'b0;
    end
  end

  always_ff @(negedge i_sys_clk) begin
    if (i_reset) begin
      word_reg <= '{tip_switch: 1'b0, pedestal_switch: 1'b0,
                    segment: SEG_RST, fine: LSB_RST};
    end else begin
      word_reg <= word_next;
    end
  end

  assign o_segment         = word_reg.segment;
  assign o_fine            = word_reg.fine;
  assign o_pedestal_switch = word_reg.pedestal_switch;
  assign o_tip_switch      = word_reg.tip_switch;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  function automatic logic [SEG_N-1:0] seg_of(input logic [MSB_W-1:0] c);
    logic [SEG_N-1:0] s;
    s = '0;
    for (int k = 0; k < SEG_N; k++) begin
      s[k] = (c > MSB_W'(k));
    end
    return s;
  endfunction

  sequence s_tip_in;
    in_sync_reg.tip_force;
  endsequence

  sequence s_tip_out;
    o_tip_switch && !o_pedestal_switch && (o_segment == SEG_ALL_SET);
  endsequence

  property p_tip;
    @(negedge i_sys_clk) disable iff (i_reset) s_tip_in |=> s_tip_out;
  endproperty

  tip_priority_a: assert property (p_tip) else $error("tip force not applied");

  pedestal_force_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    in_sync_reg.pedestal_force && !in_sync_reg.tip_force |=>
      o_pedestal_switch && !o_tip_switch && (o_segment == SEG_ALL_SET))
    else $error("pedestal force not applied");

  plain_code_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    !in_sync_reg.pedestal_force && !in_sync_reg.tip_force && !in_sync_reg.polarity_swap |=>
      {o_segment == seg_of($past(in_sync_reg.pixel[PIX_W-1:LSB_W]))} &&
      o_fine == $past(in_sync_reg.pixel[LSB_W-1:0]) && !o_pedestal_switch && !o_tip_switch)
    else $error("code path mismatch");

  swap_invert_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    in_sync_reg.polarity_swap && !in_sync_reg.pedestal_force && !in_sync_reg.tip_force |=>
      o_fine == ~$past(in_sync_reg.pixel[LSB_W-1:0]))
    else $error("swap did not invert");

  swap_extremes_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    !in_sync_reg.pedestal_force && !in_sync_reg.tip_force &&
      (in_sync_reg.pixel == {PIX_W{1'b1}}) |=>
      (o_segment == SEG_ALL_SET) == !$past(in_sync_reg.polarity_swap))
    else $error("extreme code level wrong");

  swap_isolation_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    in_sync_reg.pedestal_force || in_sync_reg.tip_force |=>
      (o_fine == LSB_ALL_SET) && (o_segment == SEG_ALL_SET))
    else $error("swap leaked into blank level");

  thermometer_shape_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    ((o_segment & (o_segment + 1'b1)) == '0))
    else $error("segments not thermometer");

  word_hold_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    ##1 $stable(in_sync_reg) && $stable($past(in_sync_reg)) |=> $stable(word_reg))
    else $error("word changed without input change");

  sequence s_no_force_in;
    !in_sync_reg.pedestal_force && !in_sync_reg.tip_force;
  endsequence

  sequence s_plain_pins;
    !i_pedestal_force && !i_tip_force && !i_polarity_swap;
  endsequence

  sequence s_word_latched;
    ##3 (o_fine == $past(i_pixel[LSB_W-1:0], 3)) &&
      (o_segment == seg_of($past(i_pixel[PIX_W-1:LSB_W], 3))) &&
      !o_pedestal_switch && !o_tip_switch;
  endsequence

  property p_pin_capture;
    @(negedge i_sys_clk) disable iff (i_reset) s_plain_pins |-> s_word_latched;
  endproperty

  pin_capture_a: assert property (p_pin_capture) else $error("pins not latched in step");

  fine_passthrough_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    s_no_force_in |=> o_fine == ($past(in_sync_reg.pixel[LSB_W-1:0]) ^
      {LSB_W{$past(in_sync_reg.polarity_swap)}}))
    else $error("fine bits not passed through");

  tip_over_pedestal_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    in_sync_reg.tip_force && in_sync_reg.pedestal_force |=>
      o_tip_switch && !o_pedestal_switch && (o_fine == LSB_ALL_SET))
    else $error("tip did not beat pedestal");

  switch_exclusive_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    !(o_tip_switch && o_pedestal_switch))
    else $error("tip and pedestal switches both on");

  zero_code_level_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    s_no_force_in ##0 (in_sync_reg.pixel == '0) |=>
      (o_segment == SEG_RST) == !$past(in_sync_reg.polarity_swap))
    else $error("zero code level wrong");

  swap_segment_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    s_no_force_in ##0 in_sync_reg.polarity_swap |=>
      o_segment == seg_of(~$past(in_sync_reg.pixel[PIX_W-1:LSB_W])))
    else $error("swap did not invert segments");

  // word before the first edge out of reset is the reset word, so skip that edge
  sequence s_forced_steady;
    (in_sync_reg.pedestal_force || in_sync_reg.tip_force) && !$past(i_reset) &&
      $stable(in_sync_reg.pedestal_force) && $stable(in_sync_reg.tip_force);
  endsequence

  blank_swap_free_a: assert property (@(negedge i_sys_clk) disable iff (i_reset)
    s_forced_steady |=> $stable(o_segment) && $stable(o_fine) &&
      $stable(o_pedestal_switch) && $stable(o_tip_switch))
    else $error("swap moved blank level");

endmodule
`default_nettype wire

// File: hw/vdac_pkg.sv
package vdac_pkg;

  localparam int unsigned PIX_W      = 10;
  localparam int unsigned MSB_W      = 6;
  localparam int unsigned LSB_W      = 4;
  localparam int unsigned SEG_N      = 63;
  localparam int unsigned STAGE_N    = 67;
  localparam int unsigned LATENCY_CYC = 1;

  localparam logic [SEG_N-1:0] SEG_ALL_SET  = {SEG_N{1'b1}};
  localparam logic [LSB_W-1:0] LSB_ALL_SET  = {LSB_W{1'b1}};
  localparam logic [SEG_N-1:0] SEG_RST      = {SEG_N{1'b0}};
  localparam logic [LSB_W-1:0] LSB_RST      = {LSB_W{1'b0}};

  typedef struct packed {
    logic             polarity_swap;
    logic             pedestal_force;
    logic             tip_force;
    logic [PIX_W-1:0] pixel;
  } video_in_t;

  typedef struct packed {
    logic             tip_switch;
    logic             pedestal_switch;
    logic [SEG_N-1:0] segment;
    logic [LSB_W-1:0] fine;
  } switch_word_t;

endpackage

// File: hw/vdac_therm_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module vdac_therm_decoder
  import vdac_pkg::*;
(
  input  wire logic [MSB_W-1:0] i_code,
  output logic      [SEG_N-1:0] o_segment
);

  genvar g;
  generate
    for (g = 0; g < SEG_N; g++) begin : g_seg
      // segment g lights once the code exceeds g
      assign o_segment[g] = (i_code > MSB_W'(g));
    end
  endgenerate

endmodule
`default_nettype wire

// File: bench/vdac_pixel_source.sv
`timescale 1ns/100ps
`default_nettype none
module vdac_pixel_source
  import vdac_pkg::*;
(
  input  wire video_in_t i_word,
  input  wire logic      i_sys_clk,
  output var  video_in_t o_word
);
  always @(posedge i_sys_clk) o_word <= #4 i_word;
endmodule
`default_nettype wire

// File: bench/video_dac_input_latch_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module video_dac_input_latch_control_bench;
  import vdac_pkg::*;
  logic         i_sys_clk = 1'b0;
  logic         i_reset   = 1'b1;
  video_in_t    req       = '0;
  video_in_t    drv;
  switch_word_t got;
  int           failures  = 0;
  int           checks    = 0;
  logic [9:0]   codes[5]  = '{10'h000, 10'h3ff, 10'h2a5, 10'h010, 10'h3ef};
  always #20 i_sys_clk = ~i_sys_clk;
  vdac_pixel_source i_vdac_pixel_source (.i_sys_clk(i_sys_clk), .i_word(req), .o_word(drv));
  vdac_input_latch i_vdac_input_latch (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pixel(drv.pixel),
    .i_polarity_swap(drv.polarity_swap), .i_pedestal_force(drv.pedestal_force),
    .i_tip_force(drv.tip_force), .o_segment(got.segment), .o_fine(got.fine),
    .o_pedestal_switch(got.pedestal_switch), .o_tip_switch(got.tip_switch));
  function automatic switch_word_t model(video_in_t w);
    logic [PIX_W-1:0] c;
    switch_word_t     s;
    c = w.polarity_swap ? ~w.pixel : w.pixel;
    for (int g = 0; g < SEG_N; g++) s.segment[g] = (int'(c[9:4]) > g);
    s.fine = c[3:0];
    s.pedestal_switch = w.pedestal_force & ~w.tip_force;
    s.tip_switch = w.tip_force;
    if (w.tip_force | w.pedestal_force) begin
      s.segment = SEG_ALL_SET;
      s.fine = LSB_ALL_SET;
    end
    return s;
  endfunction
  // source adds one rising edge, then three falling edges to the output
  task automatic settle(logic [9:0] p, logic sw, logic pf, logic tf);
    @(posedge i_sys_clk);
    req <= '{polarity_swap: sw, pedestal_force: pf, tip_force: tf, pixel: p};
    repeat (4) @(negedge i_sys_clk);
    #1;
  endtask
  task automatic t_codes(logic sw);
    foreach (codes[i]) begin
      settle(codes[i], sw, 1'b0, 1'b0);
      `CHK("gray word", model(req), got)
    end
    $display("test codes swap=%0d done", sw);
  endtask
  task automatic t_forced(logic tf);
    for (int s = 0; s < 2; s++) begin
      settle(10'h2a5, s[0], 1'b1, tf);
      `CHK("forced word", model(req), got)
    end
    settle(10'h155, 1'b0, 1'b0, tf);
    `CHK("tip alone", model(req), got)
    $display("test forced tip=%0d done", tf);
  endtask
  task automatic t_stream;
    video_in_t q[$];
    for (int i = 0; i < 12; i++) begin
      @(posedge i_sys_clk);
      #1;
      if (q.size() >= 4) `CHK("held word", model(q[$-3]), got)
      req <= '{polarity_swap: i[2], pedestal_force: i == 5, tip_force: i == 8,
               pixel: 10'(i * 83)};
      @(negedge i_sys_clk);
      #1;
      q.push_back(req);
      if (q.size() >= 4) `CHK("stream word", model(q[$-3]), got)
    end
    $display("test stream done");
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #4;
    i_reset = 1'b0;
    t_codes(1'b0);
    t_codes(1'b1);
    t_forced(1'b0);
    t_forced(1'b1);
    t_stream();
    print_verdict();
  end
endmodule
`default_nettype wire
